// *** verilog/difd_top.sv ***
`default_nettype none
// Summary of operation
// - data write starts channel calibration
// - frame is 24 bits, 32 with check
// - fixed field layout, msb first
// - top bit selects read or write
// - act only on matching device address
// - register select picks target register
// - control path needs further subselect
// - select 111 goes to control path
// - channel bits pick A to D
module difd_top
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 sclk_i,
    input  wire logic                 sync_n_i,
    input  wire logic                 sdin_i,
    input  wire logic                 hw_address_pin_hi_i,
    input  wire logic                 hw_address_pin_lo_i,
    input  wire logic                 chk_en_i,
    input  wire logic                 soft_reset_i,
    output logic [63:0]               data_regs_o,
    output logic [63:0]               gain_regs_o,
    output logic [63:0]               offset_regs_o,
    output logic [63:0]               clear_regs_o,
    output logic [3:0]                cal_busy_o,
    output difd_pkg::difd_ctrl_t      ctrl_o,
    output logic                      read_req_o,
    output logic [7:0]                read_addr_o,
    output logic [7:0]                packet_check_code_o
);
    // ------------------------------------------------
    // reset release and pin synchronisers
    // ------------------------------------------------
    logic [1:0] rst_sync_r;
    logic       rst_n;
    logic [2:0] sclk_s_r;
    logic [2:0] sync_s_r;
    logic [2:0] sdin_s_r;
    logic [2:0] ahi_s_r;
    logic [2:0] alo_s_r;
    logic       sclk_q_r;
    logic       sync_q_r;
    logic       sdin_q_r;
    logic       ahi_q_r;
    logic       alo_q_r;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rst_sync_r <= 2'b00;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n = rst_sync_r[1];

    // three stages; a level counts once stages two and three agree
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_s_r <= 3'h0;
            sync_s_r <= 3'h7;
            sdin_s_r <= 3'h0;
            ahi_s_r  <= 3'h0;
            alo_s_r  <= 3'h0;
            sclk_q_r <= 1'b0;
            sync_q_r <= 1'b1;
            sdin_q_r <= 1'b0;
            ahi_q_r  <= 1'b0;
            alo_q_r  <= 1'b0;
        end
        else
        begin
            sclk_s_r <= {sclk_s_r[1:0], sclk_i};
            sync_s_r <= {sync_s_r[1:0], sync_n_i};
            sdin_s_r <= {sdin_s_r[1:0], sdin_i};
            ahi_s_r  <= {ahi_s_r[1:0], hw_address_pin_hi_i};
            alo_s_r  <= {alo_s_r[1:0], hw_address_pin_lo_i};
            if (sclk_s_r[1] == sclk_s_r[2])
                sclk_q_r <= sclk_s_r[2];
            if (sync_s_r[1] == sync_s_r[2])
                sync_q_r <= sync_s_r[2];
            if (sdin_s_r[1] == sdin_s_r[2])
                sdin_q_r <= sdin_s_r[2];
            if (ahi_s_r[1] == ahi_s_r[2])
                ahi_q_r <= ahi_s_r[2];
            if (alo_s_r[1] == alo_s_r[2])
                alo_q_r <= alo_s_r[2];
        end
    end

    // ------------------------------------------------
    // serial clock edge enable
    // ------------------------------------------------
    logic sclk_d_r;
    logic sclk_rise;

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
            sclk_d_r <= 1'b0;
        else
            sclk_d_r <= sclk_q_r;
    end
    assign sclk_rise = sclk_q_r & ~sclk_d_r;

    logic        frame_done;
    logic [31:0] frame_word;

    difd_shifter u_shift
    (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n),
        .sclk_rise_i (sclk_rise),
        .sync_n_i    (sync_q_r),
        .sdin_i      (sdin_q_r),
        .chk_en_i    (chk_en_i),
        .done_o      (frame_done),
        .word_o      (frame_word)
    );

    // ------------------------------------------------
    // field decode
    // ------------------------------------------------
    difd_pkg::difd_frame_t frm;
    logic                  dev_match;
    logic                  do_write;

    // drop check byte when long frame
    assign frm = chk_en_i ? frame_word[31:8] : frame_word[23:0];

    assign dev_match = (frm.frame_device_sel == {ahi_q_r, alo_q_r});

    assign do_write = frame_done & dev_match & ~frm.read_not_write;

    // true when a register of channel idx is targeted by select sel
    function automatic logic hits(input logic [2:0] sel, input logic [2:0] one, input logic [2:0] all,
                                  input logic [1:0] ch, input logic [1:0] idx);
        hits = (sel == one && ch == idx) || (sel == all);
    endfunction

    // ------------------------------------------------
    // data, gain, offset and clear registers
    // ------------------------------------------------
    logic [15:0] data_r   [4];
    logic [15:0] gain_r   [4];
    logic [15:0] offset_r [4];
    logic [15:0] clear_r  [4];
    logic [3:0]  cal_start;

    // soft reset restores defaults; mismatched frames never reach here
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 4; i++)
            begin
                data_r[i]   <= difd_pkg::DATA_RST;
                gain_r[i]   <= difd_pkg::GAIN_RST;
                offset_r[i] <= difd_pkg::OFFSET_RST;
                clear_r[i]  <= difd_pkg::CLEAR_RST;
            end
        end
        else if (soft_reset_i)
        begin
            for (int i = 0; i < 4; i++)
            begin
                data_r[i]   <= difd_pkg::DATA_RST;
                gain_r[i]   <= difd_pkg::GAIN_RST;
                offset_r[i] <= difd_pkg::OFFSET_RST;
                clear_r[i]  <= difd_pkg::CLEAR_RST;
            end
        end
        else if (do_write)
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (frm.reg_select == difd_pkg::SEL_DATA && frm.channel_sel == 2'(i))
                    data_r[i] <= frm.data;
                if (hits(frm.reg_select, difd_pkg::SEL_GAIN, difd_pkg::SEL_GAIN_ALL, frm.channel_sel, 2'(i)))
                    gain_r[i] <= frm.data;
                if (hits(frm.reg_select, difd_pkg::SEL_OFFSET, difd_pkg::SEL_OFFSET_ALL, frm.channel_sel, 2'(i)))
                    offset_r[i] <= frm.data;
                if (frm.reg_select == difd_pkg::SEL_CLEAR && frm.channel_sel == 2'(i))
                    clear_r[i] <= frm.data;
            end
        end
    end

    always_comb
    begin
        for (int i = 0; i < 4; i++)
            cal_start[i] = do_write && !soft_reset_i && frm.reg_select == difd_pkg::SEL_DATA
                           && frm.channel_sel == 2'(i);
    end

    // ------------------------------------------------
    // per-channel calibration timers
    // ------------------------------------------------
    localparam int CW = $clog2(difd_pkg::CAL_CYCLES + 1);
    logic [CW-1:0] cal_cnt_r [4];

    // busy spans the settle window the host should respect
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 4; i++)
                cal_cnt_r[i] <= '0;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (cal_start[i])
                    cal_cnt_r[i] <= CW'(difd_pkg::CAL_CYCLES);
                else if (soft_reset_i)
                    cal_cnt_r[i] <= '0;
                else if (cal_cnt_r[i] != '0)
                    cal_cnt_r[i] <= cal_cnt_r[i] - CW'(1);
            end
        end
    end

    // ------------------------------------------------
    // registered outputs
    // ------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            data_regs_o   <= '0;
            gain_regs_o   <= '0;
            offset_regs_o <= '0;
            clear_regs_o  <= '0;
            cal_busy_o    <= 4'h0;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                data_regs_o[i*16 +: 16]   <= data_r[i];
                gain_regs_o[i*16 +: 16]   <= gain_r[i];
                offset_regs_o[i*16 +: 16] <= offset_r[i];
                clear_regs_o[i*16 +: 16]  <= clear_r[i];
                cal_busy_o[i]             <= (cal_cnt_r[i] != '0);
            end
        end
    end

    // control path, read requests and check byte
    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_o              <= '0;
            read_req_o          <= 1'b0;
            read_addr_o         <= 8'h00;
            packet_check_code_o <= 8'h00;
        end
        else
        begin
            ctrl_o.valid       <= do_write && !soft_reset_i && frm.reg_select == difd_pkg::SEL_CONTROL;
            ctrl_o.channel_sel <= frm.channel_sel;
            ctrl_o.data        <= frm.data;
            read_req_o         <= frame_done && dev_match && frm.read_not_write;
            if (frame_done && dev_match)
            begin
                read_addr_o         <= frm[23:16];
                packet_check_code_o <= chk_en_i ? frame_word[7:0] : 8'h00;
            end
        end
    end
endmodule
`default_nettype wire

// *** verilog/difd_pkg.sv ***
`default_nettype none
package difd_pkg;
    // frame geometry
    localparam int FRAME_BITS     = 24;
    localparam int FRAME_CHK_BITS = 32;
    localparam int RW_POS         = 23;
    localparam int DEV_HI_POS     = 22;
    localparam int DEV_LO_POS     = 21;
    localparam int REGSEL_HI_POS  = 20;
    localparam int REGSEL_LO_POS  = 18;
    localparam int CHAN_HI_POS    = 17;
    localparam int CHAN_LO_POS    = 16;
    localparam int DATA_W         = 16;
    localparam int CHK_W          = 8;

    // register select codes
    localparam logic [2:0] SEL_DATA       = 3'h0;
    localparam logic [2:0] SEL_GAIN       = 3'h2;
    localparam logic [2:0] SEL_GAIN_ALL   = 3'h3;
    localparam logic [2:0] SEL_OFFSET     = 3'h4;
    localparam logic [2:0] SEL_OFFSET_ALL = 3'h5;
    localparam logic [2:0] SEL_CLEAR      = 3'h6;
    localparam logic [2:0] SEL_CONTROL    = 3'h7;

    // reset values
    localparam logic [15:0] DATA_RST   = 16'h0000;
    localparam logic [15:0] GAIN_RST   = 16'hFFFF;
    localparam logic [15:0] OFFSET_RST = 16'h8000;
    localparam logic [15:0] CLEAR_RST  = 16'h0000;

    // calibration settle time after data write
    localparam int CLK_HZ         = 20_000_000;
    localparam int CAL_SETTLE_US  = 200;
    localparam int CAL_CYCLES     = (CAL_SETTLE_US * (CLK_HZ / 1_000_000));

    // decoded frame fields
    typedef struct packed {
        logic        read_not_write;
        logic [1:0]  frame_device_sel;
        logic [2:0]  reg_select;
        logic [1:0]  channel_sel;
        logic [15:0] data;
    } difd_frame_t;

    // control-register path output
    typedef struct packed {
        logic        valid;
        logic [1:0]  channel_sel;
        logic [15:0] data;
    } difd_ctrl_t;
endpackage
`default_nettype wire

// *** verilog/difd_shifter.sv ***
`default_nettype none
// --------------------------------------------------
// serial frame shifter
// --------------------------------------------------
module difd_shifter
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        sclk_rise_i,
    input  wire logic        sync_n_i,
    input  wire logic        sdin_i,
    input  wire logic        chk_en_i,
    output logic             done_o,
    output logic [31:0]      word_o
);
    logic [5:0]  cnt_r;
    logic [31:0] sh_r;
    logic        act_r;

    // shift msb first while frame select is low
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_r <= 6'h00;
            sh_r  <= 32'h0000_0000;
            act_r <= 1'b0;
        end
        else if (sync_n_i)
        begin
            cnt_r <= 6'h00;
            act_r <= 1'b1;
        end
        else if (sclk_rise_i && act_r)
        begin
            sh_r  <= {sh_r[30:0], sdin_i};
            cnt_r <= cnt_r + 6'h01;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            done_o <= 1'b0;
            word_o <= 32'h0000_0000;
        end
        else
        begin
            done_o <= 1'b0;
            if (sync_n_i && act_r)
            begin
                // short or long frames are dropped whole, but one 64 bits too long wraps the 6-bit count and is taken
                if (chk_en_i ? (cnt_r == 6'(difd_pkg::FRAME_CHK_BITS)) : (cnt_r == 6'(difd_pkg::FRAME_BITS)))
                begin
                    done_o <= 1'b1;
                    word_o <= sh_r;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/difd_top_assertions.sv ***
`default_nettype none
module difd_top_assertions
(
    input wire logic                 clk_i,
    input wire logic                 rst_n_i,
    input wire logic                 sync_n_i,
    input wire logic                 soft_reset_i,
    input wire logic [63:0]          data_regs_o,
    input wire logic [63:0]          gain_regs_o,
    input wire logic [3:0]           cal_busy_o,
    input wire difd_pkg::difd_ctrl_t ctrl_o,
    input wire logic                 read_req_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ----------------------------------------
    // frame timing and decode checks
    // ----------------------------------------
    // eight low cycles outlast the update pipeline of any earlier frame
    sequence s_in_frame;
        (!sync_n_i && !soft_reset_i)[*8];
    endsequence
    sequence s_cal_window;
        cal_busy_o[0][*8];
    endsequence
    property p_data_quiet;
        s_in_frame |-> $stable(data_regs_o);
    endproperty
    property p_gain_quiet;
        s_in_frame |-> $stable(gain_regs_o);
    endproperty
    property p_no_pulse;
        s_in_frame |-> !read_req_o && !ctrl_o.valid;
    endproperty
    property p_read_pulse;
        read_req_o |=> !read_req_o && $stable(data_regs_o) && $stable(gain_regs_o);
    endproperty
    property p_ctrl_pulse;
        ctrl_o.valid |=> !ctrl_o.valid && $stable(data_regs_o) && $stable(gain_regs_o);
    endproperty
    property p_cal_hold;
        $rose(cal_busy_o[0]) |=> s_cal_window;
    endproperty
    property p_cal_single;
        $onehot0(cal_busy_o & ~$past(cal_busy_o));
    endproperty
    property p_soft;
        soft_reset_i[*4] |-> gain_regs_o == {4{16'hFFFF}} && data_regs_o == 64'h0;
    endproperty
    a_data_quiet: assert property (p_data_quiet) else $error("data changed inside a frame");
    a_gain_quiet: assert property (p_gain_quiet) else $error("gain changed inside a frame");
    a_no_pulse: assert property (p_no_pulse) else $error("pulse inside a frame");
    a_read_pulse: assert property (p_read_pulse) else $error("read pulse too long or wrote");
    a_ctrl_pulse: assert property (p_ctrl_pulse) else $error("control pulse too long or wrote");
    a_cal_hold: assert property (p_cal_hold) else $error("calibration window cut short");
    a_cal_single: assert property (p_cal_single) else $error("two channels began calibration");
    a_soft: assert property (p_soft) else $error("soft reset left non-default values");
endmodule
bind difd_top difd_top_assertions u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .sync_n_i(sync_n_i),
    .soft_reset_i(soft_reset_i), .data_regs_o(data_regs_o), .gain_regs_o(gain_regs_o),
    .cal_busy_o(cal_busy_o), .ctrl_o(ctrl_o), .read_req_o(read_req_o));
`default_nettype wire

// *** tb/difd_host_model.sv ***
`default_nettype none
module difd_host_model
(
    input  wire logic clk_i,
    output var logic  sclk_o,
    output var logic  sync_n_o,
    output var logic  sdin_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // serial frame driver
    // ----------------------------------------
    initial
    begin
        sclk_o = 1'b0;
        sync_n_o = 1'b1;
        sdin_o = 1'b0;
    end
    task automatic send(input logic [31:0] w, input int n);
        @(posedge clk_i) sync_n_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        for (int i = n - 1; i >= 0; i--)
        begin
            sdin_o <= w[i];
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'b1;
            repeat (4) @(posedge clk_i);
            sclk_o <= 1'b0;
        end
        repeat (4) @(posedge clk_i);
        sync_n_o <= 1'b1;
        // released data line must not hold its last bit
        sdin_o <= ~sdin_o;
        repeat (12) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// *** tb/difd_tb_top.sv ***
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
    $display("wrong value at %0t: got %h exp %h", $time, (a), (b)); end end
module difd_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic                 clk_i = 1'b0;
    logic                 rst_n_i = 1'b0;
    logic                 sclk, sync_n, sdin, read_req;
    logic [1:0]           pins = 2'h0;
    logic                 chk_en = 1'b0;
    logic                 soft_rst = 1'b0;
    logic [63:0]          data_regs, gain_regs, offset_regs, clear_regs, b;
    logic [255:0]         snap;
    logic [3:0]           cal_busy;
    difd_pkg::difd_ctrl_t ctrl, ctrl_cap = '0;
    logic [7:0]           read_addr, pcc, n, rd_cnt = 8'h00;
    logic [23:0]          w;
    int                   failures = 0;
    int                   samples_checked = 0;
    // ----------------------------------------
    // clock, design and host
    // ----------------------------------------
    initial forever #25 clk_i = ~clk_i;
    difd_host_model u_host (.clk_i(clk_i), .sclk_o(sclk), .sync_n_o(sync_n), .sdin_o(sdin));
    difd_top uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .sync_n_i(sync_n), .sdin_i(sdin),
        .hw_address_pin_hi_i(pins[1]), .hw_address_pin_lo_i(pins[0]), .chk_en_i(chk_en),
        .soft_reset_i(soft_rst), .data_regs_o(data_regs), .gain_regs_o(gain_regs),
        .offset_regs_o(offset_regs), .clear_regs_o(clear_regs), .cal_busy_o(cal_busy), .ctrl_o(ctrl),
        .read_req_o(read_req), .read_addr_o(read_addr), .packet_check_code_o(pcc));
    // one-cycle pulses are latched so tasks can judge them later
    always @(posedge clk_i)
    begin
        if (read_req)
            rd_cnt <= rd_cnt + 8'h01;
        if (ctrl.valid)
            ctrl_cap <= ctrl;
    end
    function automatic logic [23:0] fr(logic [2:0] s, logic [1:0] c, logic [15:0] d);
        return {1'b0, pins, s, c, d};
    endfunction
    function automatic logic [63:0] bank(logic [2:0] s);
        case (s)
            3'h0: return data_regs;
            3'h2, 3'h3: return gain_regs;
            3'h4, 3'h5: return offset_regs;
            default: return clear_regs;
        endcase
    endfunction
    function automatic logic [255:0] all_regs();
        return {data_regs, gain_regs, offset_regs, clear_regs};
    endfunction
    task automatic report_and_stop();
        if (failures == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        `CHK(all_regs(), {64'h0, {4{16'hFFFF}}, {4{16'h8000}}, 64'h0})
    endtask
    task automatic t_writes();
        logic [15:0] d;
        for (int s = 0; s < 8; s += 2)
            for (int c = 0; c < 4; c++)
            begin
                d = {4'hA, s[3:0], 6'h00, c[1:0]};
                u_host.send({8'h00, fr(s[2:0], c[1:0], d)}, 24);
                b = bank(s[2:0]);
                `CHK(b[c*16 +: 16], d)
                if (s == 0)
                    `CHK(cal_busy[c], 1'b1)
            end
        for (int s = 3; s < 6; s += 2)
        begin
            d = {12'hB0B, s[3:0]};
            u_host.send({8'h00, fr(s[2:0], 2'h1, d)}, 24);
            `CHK(bank(s[2:0]), {4{d}})
        end
    endtask
    task automatic t_refuse();
        snap = all_regs();
        u_host.send({8'h00, 1'b0, ~pins, 3'h6, 2'h0, 16'hDEAD}, 24);
        u_host.send({8'h00, fr(3'h1, 2'h0, 16'hDEAD)}, 24);
        // a 23-bit frame is short by one and must be dropped
        u_host.send({8'h00, fr(3'h6, 2'h0, 16'hDEAD)}, 23);
        `CHK(all_regs(), snap)
    endtask
    task automatic t_pins();
        for (int p = 0; p < 4; p++)
        begin
            pins <= p[1:0];
            repeat (4) @(posedge clk_i);
            u_host.send({8'h00, fr(3'h6, p[1:0], {14'h1680, p[1:0]})}, 24);
            u_host.send({8'h00, 1'b0, ~p[1:0], 3'h6, p[1:0], 16'hDEAD}, 24);
            `CHK(clear_regs[p*16 +: 16], {14'h1680, p[1:0]})
        end
    endtask
    task automatic t_read();
        n = rd_cnt;
        snap = all_regs();
        w = {1'b1, pins, 3'h0, 2'h2, 16'h1234};
        u_host.send({8'h00, w}, 24);
        `CHK(rd_cnt, n + 8'h01)
        `CHK(read_addr, w[23:16])
        `CHK(all_regs(), snap)
    endtask
    task automatic t_ctrl();
        snap = all_regs();
        u_host.send({8'h00, fr(3'h7, 2'h0, 16'h5A0C)}, 24);
        `CHK(ctrl_cap, {1'b1, 2'h0, 16'h5A0C})
        u_host.send({8'h00, fr(3'h7, 2'h3, 16'hC3A5)}, 24);
        `CHK(ctrl_cap, {1'b1, 2'h3, 16'hC3A5})
        `CHK(all_regs(), snap)
    endtask
    task automatic t_chk();
        // pins are 11 here, never 00 with check byte
        chk_en <= 1'b1;
        u_host.send({fr(3'h0, 2'h1, 16'h7777), 8'h96}, 32);
        `CHK(data_regs[31:16], 16'h7777)
        `CHK(pcc, 8'h96)
        chk_en <= 1'b0;
    endtask
    task automatic t_cal();
        // zero code before output goes off
        u_host.send({8'h00, fr(3'h0, 2'h0, 16'h0000)}, 24);
        `CHK(data_regs[15:0], 16'h0000)
        u_host.send({8'h00, fr(3'h7, 2'h0, 16'h0A51)}, 24);
        `CHK(ctrl_cap, {1'b1, 2'h0, 16'h0A51})
        u_host.send({8'h00, fr(3'h0, 2'h0, 16'h4000)}, 24);
        `CHK(data_regs[15:0], 16'h4000)
        repeat (3980) @(posedge clk_i);
        `CHK(cal_busy[0], 1'b1)
        repeat (40) @(posedge clk_i);
        `CHK(cal_busy[0], 1'b0)
        u_host.send({8'h00, fr(3'h7, 2'h0, 16'h0A59)}, 24);
        `CHK(ctrl_cap, {1'b1, 2'h0, 16'h0A59})
    endtask
    task automatic t_soft();
        soft_rst <= 1'b1;
        repeat (4) @(posedge clk_i);
        u_host.send({8'h00, fr(3'h0, 2'h2, 16'h4321)}, 24);
        `CHK(all_regs(), {64'h0, {4{16'hFFFF}}, {4{16'h8000}}, 64'h0})
        `CHK(cal_busy[2], 1'b0)
        soft_rst <= 1'b0;
    endtask
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        t_reset();
        t_writes();
        t_refuse();
        t_pins();
        t_read();
        t_ctrl();
        t_chk();
        t_cal();
        t_soft();
        report_and_stop();
    end
    // whole run needs about 12200 cycles
    initial
    begin
        repeat (30000) @(posedge clk_i);
        failures++;
        report_and_stop();
    end
endmodule
`default_nettype wire
